//--- rtl/dcc_defines.svh
// register offsets, field positions and reset values of the dual comparator control block
// assumes inclusion by bare name from every design file that needs them
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_OFS_CTRL0 6'h00
`define DCC_OFS_CTRL1 6'h01
`define DCC_OFS_STAT 6'h02
`define DCC_OFS_FLAG 6'h03
`define DCC_OFS_IRQ_STAT 6'h04
`define DCC_OFS_IRQ_MASK 6'h05
`define DCC_CTL_ON 7
`define DCC_CTL_PIN 6
`define DCC_CTL_INV 5
`define DCC_CTL_EV_HI 4
`define DCC_CTL_EV_LO 3
`define DCC_CTL_POS 2
`define DCC_CTL_NEG_HI 1
`define DCC_CTL_NEG_LO 0
`define DCC_CTRL_RESET 8'h1f
`define DCC_LARGE_PACKAGE 1'b1
`define DCC_CHANNELS 2
`endif

//--- rtl/dcc_pkg.sv
// types shared by the dual comparator control block
// assumes dcc_defines.svh for the numeric constants
package dcc_pkg;
   typedef logic [7:0] dcc_ctrl_t;
   typedef enum logic [1:0] {dcc_ev_never, dcc_ev_rise, dcc_ev_fall, dcc_ev_any} dcc_event_e;
   typedef enum logic [1:0] {dcc_neg_b, dcc_neg_c, dcc_neg_d, dcc_neg_fixed} dcc_neg_e;
endpackage

//--- rtl/dcc_chan_if.sv
// carrier between the register block and one comparator channel
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface dcc_chan_if;
   import dcc_pkg::*;
   dcc_ctrl_t ctrl;
   logic raw;
   logic result;
   logic event_pulse;
   modport chan (input ctrl, input raw, output result, output event_pulse);
   modport regs (output ctrl, output raw, input result, input event_pulse);
endinterface

//--- rtl/dcc_channel.sv
// one comparator channel: synchroniser, polarity, edge detection, event qualification
// assumes the raw comparator level is asynchronous to clk_i
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_channel
   import dcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   dcc_chan_if.chan ch
);
   logic meta_r, meta_nxt;
   logic sync_r, sync_nxt;
   logic res_r, res_nxt;
   logic ev_r, ev_nxt;
   logic adj;
   dcc_event_e ev_sel;

   always_comb begin
      meta_nxt = ch.raw;
      sync_nxt = meta_r;
      ev_sel = dcc_event_e'(ch.ctrl[`DCC_CTL_EV_HI:`DCC_CTL_EV_LO]);
      // a disabled channel reads low so it cannot raise spurious events
      adj = ch.ctrl[`DCC_CTL_ON] ? (sync_r ^ ch.ctrl[`DCC_CTL_INV]) : 1'b0;
      res_nxt = adj;
      case (ev_sel)
         dcc_ev_rise: ev_nxt = adj & ~res_r;
         dcc_ev_fall: ev_nxt = ~adj & res_r;
         dcc_ev_any: ev_nxt = adj ^ res_r;
         default: ev_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         res_r <= 1'b0;
         ev_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         res_r <= res_nxt;
         ev_r <= ev_nxt;
      end
   end

   assign ch.result = res_r;
   assign ch.event_pulse = ev_r;
endmodule

//--- rtl/dcc_top.sv
// dual comparator control: classic wishbone register slave, two channels, pin and select outputs
// assumes analog front ends deliver raw levels and consume the select outputs; single clock
// Summary of operation
// - two channels, each with its own control register, result bit and event flag.
// - control bit 7 turns the channel on when one and off when zero.
// - control bit 6 routes the channel result to its output pin, otherwise the pin keeps normal port data.
// - control bit 5 inverts the raw result before status, pin and event logic.
// - bits 4-3 pick the event: 11 any change, 10 falling, 01 rising, 00 never.
// - selecting the any-change event sets the flag, which software clears after setup.
// - control bit 2 picks the programmable reference when one, input a pin when zero, for the positive input.
// - bits 1-0 pick the negative input: 11 fixed reference, 10 input d, 01 input c, 00 input b.
// - the input c and d choices exist only in the large package variant and select nothing otherwise.
// - status holds channel 2 result in bit 1 and channel 1 in bit 0, upper bits zero, read only.
// - the raw result is high when the positive input exceeds the negative input.
// - with inversion off a status one means positive above negative, with inversion on below.
// - an event flag stays set until software clears it, and writing one sets it.
// - flags are set on qualifying edges whatever the interrupt mask says.
// - with pin output on, the port tristate bit still acts as the pin output enable.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_top
   import dcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic [1:0] cmp_raw_i,
   input wire logic [1:0] port_data_i,
   input wire logic [1:0] port_tris_i,
   output logic [1:0] channel_on_o,
   output logic [1:0] positive_source_select_o,
   output logic [7:0] negative_source_select_o,
   output logic [1:0] result_pin_o,
   output logic [1:0] result_pin_oe_o
);
   dcc_ctrl_t ctrl_r [`DCC_CHANNELS];
   dcc_ctrl_t ctrl_nxt [`DCC_CHANNELS];
   logic [1:0] flag_r, flag_nxt;
   logic [1:0] irq_stat_r, irq_stat_nxt;
   logic [1:0] irq_mask_r, irq_mask_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic irq_r, irq_nxt;
   logic [1:0] on_r, on_nxt;
   logic [1:0] pos_r, pos_nxt;
   logic [7:0] neg_r, neg_nxt;
   logic [1:0] pin_r, pin_nxt;
   logic [1:0] pin_oe_r, pin_oe_nxt;
   logic [1:0] result;
   logic [1:0] event_pulse;
   logic [1:0] auto_set;
   logic [5:0] word;
   logic done;
   logic wr;
   logic rd;

   dcc_chan_if chan_if [`DCC_CHANNELS] ();

   // the generate loop gives each channel its own instance and carrier
   genvar g;
   generate
      for (g = 0; g < `DCC_CHANNELS; g++) begin : gen_chan
         assign chan_if[g].ctrl = ctrl_r[g];
         assign chan_if[g].raw = cmp_raw_i[g];
         assign result[g] = chan_if[g].result;
         assign event_pulse[g] = chan_if[g].event_pulse;
         dcc_channel u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ch(chan_if[g])
         );
      end
   endgenerate

   // bus transfer completes at the edge where the master samples ack high
   always_comb begin
      word = wb_adr_i[7:2];
      ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
      done = wb_cyc_i & wb_stb_i & ack_r;
      wr = done & wb_we_i & wb_sel_i[0];
      rd = done & ~wb_we_i;
   end

   // read data is registered when ack rises, so it is stable while ack is high
   always_comb begin
      dat_nxt = dat_r;
      if (ack_nxt & ~wb_we_i) begin
         dat_nxt = 32'h0;
         case (word)
            `DCC_OFS_CTRL0: dat_nxt[7:0] = ctrl_r[0];
            `DCC_OFS_CTRL1: dat_nxt[7:0] = ctrl_r[1];
            `DCC_OFS_STAT: dat_nxt[1:0] = result;
            `DCC_OFS_FLAG: dat_nxt[1:0] = flag_r;
            `DCC_OFS_IRQ_STAT: dat_nxt[1:0] = irq_stat_r;
            `DCC_OFS_IRQ_MASK: dat_nxt[1:0] = irq_mask_r;
            default: dat_nxt = 32'h0;
         endcase
      end
   end

   // control registers; a write to the status word is ignored
   always_comb begin
      for (int i = 0; i < `DCC_CHANNELS; i++) begin
         ctrl_nxt[i] = ctrl_r[i];
         auto_set[i] = 1'b0;
      end
      if (wr && word == `DCC_OFS_CTRL0) begin
         ctrl_nxt[0] = wb_dat_i[7:0];
      end
      if (wr && word == `DCC_OFS_CTRL1) begin
         ctrl_nxt[1] = wb_dat_i[7:0];
      end
      for (int i = 0; i < `DCC_CHANNELS; i++) begin
         if (wr && word == 6'(i) &&
             dcc_event_e'(wb_dat_i[`DCC_CTL_EV_HI:`DCC_CTL_EV_LO]) == dcc_ev_any) begin
            auto_set[i] = 1'b1;
         end
      end
   end

   // event flags: software write loads the value, hardware set wins over a clear
   always_comb begin
      flag_nxt = flag_r;
      if (wr && word == `DCC_OFS_FLAG) begin
         flag_nxt = wb_dat_i[1:0];
      end
      flag_nxt = flag_nxt | event_pulse | auto_set;
   end

   // interrupt status is cleared by reading it; an event in the same cycle survives
   always_comb begin
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      if (rd && word == `DCC_OFS_IRQ_STAT) begin
         irq_stat_nxt = 2'h0;
      end
      irq_stat_nxt = irq_stat_nxt | event_pulse | auto_set;
      if (wr && word == `DCC_OFS_IRQ_MASK) begin
         irq_mask_nxt = wb_dat_i[1:0];
      end
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   // analog selects and pin path, all registered so outputs come from flops
   always_comb begin
      for (int i = 0; i < `DCC_CHANNELS; i++) begin
         on_nxt[i] = ctrl_r[i][`DCC_CTL_ON];
         pos_nxt[i] = ctrl_r[i][`DCC_CTL_POS];
         neg_nxt[i*4 +: 4] = 4'h0;
         case (dcc_neg_e'(ctrl_r[i][`DCC_CTL_NEG_HI:`DCC_CTL_NEG_LO]))
            dcc_neg_b: neg_nxt[i*4 +: 4] = 4'h1;
            dcc_neg_c: neg_nxt[i*4 +: 4] = `DCC_LARGE_PACKAGE ? 4'h2 : 4'h0;
            dcc_neg_d: neg_nxt[i*4 +: 4] = `DCC_LARGE_PACKAGE ? 4'h4 : 4'h0;
            dcc_neg_fixed: neg_nxt[i*4 +: 4] = 4'h8;
            default: neg_nxt[i*4 +: 4] = 4'h0;
         endcase
         // the tristate bit keeps control of the driver in both modes
         pin_nxt[i] = ctrl_r[i][`DCC_CTL_PIN] ? result[i] : port_data_i[i];
         pin_oe_nxt[i] = ~port_tris_i[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DCC_CHANNELS; i++) begin
            ctrl_r[i] <= `DCC_CTRL_RESET;
         end
      end else begin
         for (int i = 0; i < `DCC_CHANNELS; i++) begin
            ctrl_r[i] <= ctrl_nxt[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_r <= 2'h0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_r <= 2'h0;
         pos_r <= 2'h0;
         neg_r <= 8'h0;
         pin_r <= 2'h0;
         pin_oe_r <= 2'h0;
      end else begin
         on_r <= on_nxt;
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
         pin_r <= pin_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   // results after a selection change are not masked here; software waits the response time
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq_o = irq_r;
   assign channel_on_o = on_r;
   assign positive_source_select_o = pos_r;
   assign negative_source_select_o = neg_r;
   assign result_pin_o = pin_r;
   assign result_pin_oe_o = pin_oe_r;
endmodule

//--- tb/dcc_top_assertions.sv
// checker for dcc_top: bus timing, select outputs, pin routing, irq masking
// assumes it is bound into dcc_top and sees only its ports
`timescale 1ns/1ps
module dcc_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic [1:0] port_data_i,
   input wire logic [1:0] port_tris_i,
   input wire logic [1:0] channel_on_o,
   input wire logic [1:0] positive_source_select_o,
   input wire logic [7:0] negative_source_select_o,
   input wire logic [1:0] result_pin_o,
   input wire logic [1:0] result_pin_oe_o
);
   // shadow of the software view, since the real registers are hidden
   logic [7:0] c0_r, c1_r, m_r, c0_nxt, c1_nxt, m_nxt;
   logic wr;
   always_comb begin
      wr = wb_ack_o && wb_stb_i && wb_we_i && wb_sel_i[0];
      c0_nxt = (wr && wb_adr_i[7:2] == 6'h00) ? wb_dat_i[7:0] : c0_r;
      c1_nxt = (wr && wb_adr_i[7:2] == 6'h01) ? wb_dat_i[7:0] : c1_r;
      m_nxt = (wr && wb_adr_i[7:2] == 6'h05) ? wb_dat_i[7:0] : m_r;
   end
   always_ff @(posedge clk_i) begin
      c0_r <= rst_i ? 8'h1f : c0_nxt;
      c1_r <= rst_i ? 8'h1f : c1_nxt;
      m_r <= rst_i ? 8'h00 : m_nxt;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   ack_latency_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   channel_on_a: assert property (!$past(rst_i) |->
      channel_on_o == {$past(c1_r[7]), $past(c0_r[7])}) else $error("enable wrong");
   pos_sel_a: assert property (!$past(rst_i) |->
      positive_source_select_o == {$past(c1_r[2]), $past(c0_r[2])}) else $error("pos select wrong");
   neg_sel_a: assert property (!$past(rst_i) |->
      negative_source_select_o == {4'h1 << $past(c1_r[1:0]), 4'h1 << $past(c0_r[1:0])})
      else $error("neg select wrong");
   pin_mux_a: assert property (!$past(rst_i) && !$past(c0_r[6]) |->
      result_pin_o[0] == $past(port_data_i[0])) else $error("pin not port data");
   pin_oe_a: assert property (!$past(rst_i) |->
      result_pin_oe_o == ~$past(port_tris_i)) else $error("pin enable wrong");
   irq_mask_a: assert property (!$past(rst_i) && m_r[1:0] == 2'h0 |-> !irq_o)
      else $error("irq while masked");
   stat_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h02 |->
      wb_dat_o[31:2] == 30'h0) else $error("status upper bits");
   ctrl_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h01 |->
      wb_dat_o[7:0] == c1_r) else $error("ctrl readback");
endmodule
bind dcc_top dcc_checker i_chk (.*);

//--- tb/dcc_front_model.sv
// analog front end model: two comparators fed by the selected sources
// assumes levels are plain numbers driven by the bench
`timescale 1ns/1ps
module dcc_front_model (
   input wire logic [1:0] positive_source_select_i,
   input wire logic [7:0] negative_source_select_i,
   input wire logic [15:0] level_a_i,
   input wire logic [15:0] level_b_i,
   output logic [1:0] cmp_raw_o
);
   // c and d sit either side of the reference so each choice shows in the result
   localparam logic [7:0] PROG_REF = 8'h80, FIXED_REF = 8'h60, LEVEL_C = 8'h20, LEVEL_D = 8'he0;
   logic [7:0] vp, vn;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         vp = positive_source_select_i[i] ? PROG_REF : level_a_i[i*8+:8];
         case (negative_source_select_i[i*4+:4])
            4'h1: vn = level_b_i[i*8+:8];
            4'h2: vn = LEVEL_C;
            4'h4: vn = LEVEL_D;
            default: vn = FIXED_REF;
         endcase
         cmp_raw_o[i] = vp > vn;
      end
   end
endmodule

//--- tb/dcc_top_tb.sv
// bench for dcc_top: wishbone tasks, front end model, fixed sequence
// assumes the checker binds itself into the top
`timescale 1ns/1ps
module dcc_top_tb;
   logic clk_i = 0, rst_i = 1, req = 0, we = 0, ack, irq;
   logic [7:0] adr = 0, neg;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic [1:0] raw, pdat = 0, tris = 2'b11, on, pos, pin, oe;
   logic [15:0] lva = 16'h1010, lvb = 16'h4040;
   int error_cnt = 0, check_count = 0;
   initial forever #25 clk_i = ~clk_i;
   dcc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .cmp_raw_i(raw),
      .port_data_i(pdat), .port_tris_i(tris), .channel_on_o(on), .positive_source_select_o(pos),
      .negative_source_select_o(neg), .result_pin_o(pin), .result_pin_oe_o(oe));
   dcc_front_model i_fe (.positive_source_select_i(pos), .negative_source_select_i(neg), .level_a_i(lva),
      .level_b_i(lvb), .cmp_raw_o(raw));
   task automatic stop_test();
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // ack and read data are taken at the rising edge that ends the ack cycle; one idle cycle follows
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
      if (ack !== 1'b1) error_cnt++;
      q = rdat;
      req <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h00, 4'h0);
      cmp(q, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h00, 32'h1f);
      rd(8'h04, 32'h1f);
      rd(8'h3c, 32'h0);
      wr(8'h00, 8'h80);
      wt(6);
      rd(8'h08, 32'h0);
      wr(8'h00, 8'ha0);
      wr(8'h08, 8'hff);
      wt(6);
      rd(8'h08, 32'h1);
      rd(8'h0c, 32'h0);
      for (int ev = 0; ev < 4; ev++) begin
         lva <= 16'h1010;
         wt(6);
         wr(8'h0c, 8'h00);
         wr(8'h00, 8'h80 | 8'(ev << 3));
         rd(8'h0c, 32'(ev == 3));
         wr(8'h0c, 8'h00);
         lva <= 16'h1090;
         wt(6);
         rd(8'h0c, 32'(ev % 2));
         cmp({31'h0, irq}, 32'h0);
         wr(8'h0c, 8'h00);
         lva <= 16'h1010;
         wt(6);
         rd(8'h0c, 32'(ev / 2));
      end
      wr(8'h00, 8'h88);
      wr(8'h0c, 8'h00);
      xfer(1'b0, 8'h10, 8'h00, 4'h0);
      wr(8'h14, 8'h01);
      lva <= 16'h1090;
      wt(8);
      cmp({31'h0, irq}, 32'h1);
      rd(8'h10, 32'h1);
      wt(3);
      cmp({31'h0, irq}, 32'h0);
      wr(8'h0c, 8'h02);
      wt(4);
      rd(8'h0c, 32'h2);
      wr(8'h00, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(8'h04, 8'h84 | 8'(k));
         wt(6);
         cmp({14'h0, on, neg, 6'h0, pos}, {14'h0, 2'b10, 4'(1 << k), 4'h1, 8'h02});
         rd(8'h08, {30'h0, 1'(k != 2), 1'b0});
      end
      wr(8'h00, 8'hc0);
      pdat <= 2'b10;
      tris <= 2'b10;
      wt(6);
      cmp({30'h0, pin}, 32'h3);
      cmp({30'h0, oe}, 32'h1);
      xfer(1'b1, 8'h00, 8'h00, 4'h0);
      rd(8'h00, 32'hc0);
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      stop_test();
   end
endmodule
